// [codec_serial_port.sv]
`timescale 1ns/1ps
// Summary of operation
// - One primary sample transfer every frame; secondary only when requested.
// - Control 1 bit 0 picks 15 or 16 bit words; resets to 15.
// - In 15-bit mode input bit 0 set requests a secondary transfer.
// - In 16-bit mode all bits are data; only the pin requests secondary.
// - Frame sync low, 16 bits out and in, then frame sync high.
// - Control registers change only in secondary transfers, one word each.
// - Secondary word addressed to register zero changes nothing.
// - Write data arrives on input line; read data leaves on output line.
// - Request pin sampled at primary frame sync rising edge.
// - Secondary frame sync falls 128 bit clocks after primary start.
// - Words go MSB first; bit 0 of 15-bit words is request flag.
// - Sample words are two's complement both ways.
// - Bit clock runs at 256 times the frame rate.
// - Status output pin follows a bit of control register 2.
// - Monitor input level is shown during secondary transfers.
// - Secondary input bit 13: one reads, zero writes.
// - Frame sync falls on bit clock rise, low for whole word.
module codec_serial_port
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic sclk,
  output logic frame_sync_n,
  output logic dout,
  output logic dout_oe,
  input wire logic din,
  input wire logic hw_secondary_request,
  input wire logic ext_monitor_in,
  output logic flag_out
);

  frame_timing_if tif ();

  frame_timing timing_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tif(tif.gen)
  );

  logic [2:0] pin_raw;
  logic [2:0] pin_f;
  assign pin_raw = {ext_monitor_in, hw_secondary_request, din};

  input_sync #(.WIDTH(3)) sync_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(pin_raw),
    .q(pin_f)
  );

  logic din_f;
  logic req_f;
  logic mon_f;
  assign din_f = pin_f[0];
  assign req_f = pin_f[1];
  assign mon_f = pin_f[2];

  phase_t phase_reg;
  logic sclk_reg;
  logic fs_n_reg;
  logic dout_reg;
  logic oe_reg;
  logic flag_reg;
  logic sec_pending_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [15:0] dac_in_reg;
  logic [15:0] sec_word_reg;
  logic [15:0] adc_out_reg;
  logic [7:0] ctrl_reg [NUM_CTRL];

  logic [3:0] idx;
  logic [2:0] sec_addr;
  logic sec_read;
  logic mode16;
  logic [7:0] sel_ctrl;
  logic sec_bit;
  logic pri_end;
  logic sec_end;
  logic [1:0] fall_d_reg;

  assign idx = ~tif.pos[3:0];
  assign sec_addr = rx_reg[SEC_ADDR_HI:SEC_ADDR_LO];
  assign sec_read = rx_reg[SEC_RW_BIT];
  assign mode16 = ctrl_reg[MODE_REG][MODE16_BIT];
  assign pri_end = ce && tif.rise && (phase_reg == PH_PRIMARY) && (tif.pos == PRI_END);
  assign sec_end = ce && tif.rise && (phase_reg == PH_SECONDARY) && (tif.pos == SEC_END);

  always_comb begin
    sel_ctrl = CTRL_RESET;
    if ((sec_addr != ADDR_NOP) && (sec_addr <= ADDR_LAST)) begin
      sel_ctrl = ctrl_reg[2'(sec_addr - 3'h1)];
    end
  end

  // Read data goes out once the address bits have been taken in
  always_comb begin
    sec_bit = 1'b0;
    if (idx == 4'(SEC_MON_BIT)) begin
      sec_bit = mon_f;
    end else if ((idx <= 4'(SEC_DATA_TOP)) && sec_read) begin
      sec_bit = sel_ctrl[idx[2:0]];
    end
  end

  // Frame sequencing on bit clock rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= PH_IDLE;
      fs_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else if (ce && tif.rise) begin
      case (phase_reg)
        PH_IDLE, PH_GAP: begin
          if (tif.pos == PRI_START) begin
            phase_reg <= PH_PRIMARY;
            fs_n_reg <= 1'b0;
            oe_reg <= 1'b1;
            dout_reg <= adc_out_reg[15];
          end else if ((tif.pos == SEC_START) && sec_pending_reg) begin
            phase_reg <= PH_SECONDARY;
            fs_n_reg <= 1'b0;
            oe_reg <= 1'b1;
            dout_reg <= sec_bit;
          end
        end
        PH_PRIMARY: begin
          if (tif.pos == PRI_END) begin
            phase_reg <= PH_GAP;
            fs_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
          end else begin
            dout_reg <= tx_reg[idx];
          end
        end
        PH_SECONDARY: begin
          if (tif.pos == SEC_END) begin
            phase_reg <= PH_IDLE;
            fs_n_reg <= 1'b1;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
          end else begin
            dout_reg <= sec_bit;
          end
        end
        default: begin
          phase_reg <= PH_IDLE;
          fs_n_reg <= 1'b1;
          oe_reg <= 1'b0;
          dout_reg <= 1'b0;
        end
      endcase
    end
  end

  // Snapshot so a bus write mid-word cannot tear the sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reg <= WORD_RESET;
    end else if (ce && tif.rise && (tif.pos == PRI_START)) begin
      tx_reg <= adc_out_reg;
    end
  end

  // Taken two clocks after the fall; the pin synchroniser lags four clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_reg <= WORD_RESET;
    end else if (ce && fall_d_reg[1] &&
                 ((phase_reg == PH_PRIMARY) || (phase_reg == PH_SECONDARY))) begin
      rx_reg[idx] <= din_f;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_in_reg <= WORD_RESET;
      sec_word_reg <= WORD_RESET;
    end else if (pri_end) begin
      dac_in_reg <= rx_reg;
    end else if (sec_end) begin
      sec_word_reg <= rx_reg;
    end
  end

  // Request latched as frame sync rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_pending_reg <= 1'b0;
    end else if (pri_end) begin
      sec_pending_reg <= req_f || (!mode16 && rx_reg[REQ_BIT]);
    end else if (sec_end) begin
      sec_pending_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CTRL; g++) begin : g_ctrl
      // Address 0 matches no entry, so a no-op leaves all alone
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_reg[g] <= CTRL_RESET;
        end else if (sec_end && !sec_read && (sec_addr == 3'(g + 1))) begin
          ctrl_reg[g] <= rx_reg[SEC_DATA_TOP:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
      sclk_reg <= 1'b0;
      fall_d_reg <= 2'h0;
    end else if (ce) begin
      flag_reg <= ctrl_reg[FLAG_REG][FLAG_BIT];
      sclk_reg <= tif.sclk;
      fall_d_reg <= {fall_d_reg[0], tif.fall};
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  logic aw_held_reg;
  logic w_held_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [7:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic do_write;
  logic [31:0] rd_mux;
  logic rd_ok;

  assign do_write = ce && aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (ce) begin
      if (awvalid && awready_reg) begin
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b0;
      w_data_reg <= WORD_RESET;
      w_strb_reg <= 2'h0;
    end else if (ce) begin
      if (wvalid && wready_reg) begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= wdata[15:0];
        w_strb_reg <= wstrb[1:0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg == ADDR_ADC_OUT) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Outgoing sample, two's complement, taken as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_out_reg <= WORD_RESET;
    end else if (do_write && (aw_addr_reg == ADDR_ADC_OUT)) begin
      if (w_strb_reg[0]) begin
        adc_out_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        adc_out_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (araddr)
      ADDR_ADC_OUT: rd_mux = {16'h0000, adc_out_reg};
      ADDR_DAC_IN: rd_mux = {16'h0000, dac_in_reg};
      ADDR_STATUS: rd_mux = {25'h0000000, sec_pending_reg, mon_f, flag_reg, mode16,
                             fs_n_reg, phase_reg};
      ADDR_CTRL: rd_mux = {ctrl_reg[3], ctrl_reg[2], ctrl_reg[1], ctrl_reg[0]};
      ADDR_SEC_WORD: rd_mux = {16'h0000, sec_word_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign sclk = sclk_reg;
  assign frame_sync_n = fs_n_reg;
  assign dout = dout_reg;
  assign dout_oe = oe_reg;
  assign flag_out = flag_reg;

endmodule : codec_serial_port

// [codec_port_pkg.sv]
package codec_port_pkg;

  // Clocking
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_DIV = SCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] DIV_LAST = 3'(SCLK_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(SCLK_DIV / 2 - 1);
  localparam logic [2:0] DIV_RESET = 3'h0;

  // Frame positions in bit clocks, 256 per frame
  localparam int FRAME_BITS = 256;
  localparam logic [7:0] POS_RESET = 8'(FRAME_BITS - 1);
  localparam logic [7:0] PRI_START = 8'h00;
  localparam logic [7:0] PRI_END = 8'h10;
  localparam logic [7:0] SEC_START = 8'h80;
  localparam logic [7:0] SEC_END = 8'h90;

  // Secondary word layout
  localparam int SEC_MON_BIT = 15;
  localparam int SEC_RW_BIT = 13;
  localparam int SEC_ADDR_HI = 10;
  localparam int SEC_ADDR_LO = 8;
  localparam int SEC_DATA_TOP = 7;
  localparam logic [2:0] ADDR_NOP = 3'h0;
  localparam int NUM_CTRL = 4;
  localparam logic [2:0] ADDR_LAST = 3'(NUM_CTRL);
  localparam int REQ_BIT = 0;

  // Control registers
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MODE_REG = 0;
  localparam int MODE16_BIT = 0;
  localparam int FLAG_REG = 1;
  localparam int FLAG_BIT = 0;

  // AXI4-Lite map
  localparam logic [7:0] ADDR_ADC_OUT = 8'h00;
  localparam logic [7:0] ADDR_DAC_IN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_SEC_WORD = 8'h10;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_PRIMARY = 2'h1,
    PH_GAP = 2'h3,
    PH_SECONDARY = 2'h2
  } phase_t;

endpackage : codec_port_pkg

// [frame_timing_if.sv]
`timescale 1ns/1ps
interface frame_timing_if;
  logic sclk;
  logic rise;
  logic fall;
  logic [7:0] pos;
  modport gen (output sclk, output rise, output fall, output pos);
  modport use_side (input sclk, input rise, input fall, input pos);
endinterface : frame_timing_if

// [frame_timing.sv]
`timescale 1ns/1ps
module frame_timing
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  frame_timing_if.gen tif
);

  logic [2:0] div_reg;
  logic sclk_reg;
  logic rise_reg;
  logic fall_reg;
  logic [7:0] pos_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= DIV_RESET;
    end else if (ce) begin
      div_reg <= (div_reg == DIV_LAST) ? DIV_RESET : div_reg + 3'h1;
    end
  end

  // Bit clock is 256 per frame; pos wraps once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      pos_reg <= POS_RESET;
    end else if (ce) begin
      rise_reg <= (div_reg == DIV_LAST);
      fall_reg <= (div_reg == DIV_HALF);
      if (div_reg == DIV_LAST) begin
        sclk_reg <= 1'b1;
        pos_reg <= pos_reg + 8'h01;
      end else if (div_reg == DIV_HALF) begin
        sclk_reg <= 1'b0;
      end
    end
  end

  assign tif.sclk = sclk_reg;
  assign tif.rise = rise_reg;
  assign tif.fall = fall_reg;
  assign tif.pos = pos_reg;

endmodule : frame_timing

// [input_sync.sv]
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      // First stage feeds only the second
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= d[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q[g] = q_reg;
    end
  endgenerate

endmodule : input_sync

// [codec_serial_port_monitor.sv]
`timescale 1ns/1ps
module codec_serial_port_monitor
  import codec_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic dout_oe
);
  logic [11:0] lo_cnt;
  logic [11:0] hi_cnt;
  logic seen;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Run lengths; the first gap after reset is not a full frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_cnt <= '0;
      hi_cnt <= '0;
      seen <= 1'b0;
    end else begin
      lo_cnt <= frame_sync_n ? '0 : lo_cnt + 12'h001;
      hi_cnt <= frame_sync_n ? hi_cnt + 12'h001 : '0;
      if (frame_sync_n && lo_cnt != '0) seen <= 1'b1;
    end
  end
  fs_low_len_a: assert property ($rose(frame_sync_n) |-> lo_cnt == 12'h080)
    else $error("frame sync low length wrong");
  frame_gap_a: assert property (seen && $fell(frame_sync_n) |->
    hi_cnt == 12'h380 || hi_cnt == 12'h780)
    else $error("frame sync gap wrong");
  sclk_period_a: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk [*4] ##1 sclk)
    else $error("bit clock period wrong");
  fs_on_rise_a: assert property ($fell(frame_sync_n) |-> $rose(sclk))
    else $error("frame sync fell off bit clock rise");
  oe_with_fs_a: assert property (dout_oe == !frame_sync_n)
    else $error("output enable not with frame sync");
  write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid
    && bresp == ($past(awaddr, 2) == ADDR_ADC_OUT ? RESP_OKAY : RESP_SLVERR))
    else $error("write response wrong");
  bad_read_a: assert property (arvalid && arready && araddr > ADDR_SEC_WORD |=>
    rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");
  aw_drop_a: assert property (awvalid && awready |=> !awready)
    else $error("write address ready held");
  r_done_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read valid held after handshake");
  cover property (seen && $fell(frame_sync_n) && hi_cnt == 12'h380);
  cover property (seen && $fell(frame_sync_n) && hi_cnt == 12'h780);
  cover property (arvalid && arready && araddr > ADDR_SEC_WORD);
endmodule : codec_serial_port_monitor

// [host_dsp_model.sv]
`timescale 1ns/1ps
module host_dsp_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic dout,
  input wire logic [15:0] tx_word,
  output logic din,
  output logic [15:0] rx_word,
  output logic rx_done
);
  logic sclk_q;
  logic fs_q;
  logic fs_d;
  logic [4:0] k;
  always_ff @(posedge aclk) begin
    sclk_q <= sclk;
    fs_q <= frame_sync_n;
    fs_d <= fs_q;
  end
  // Delayed sync keeps D15 up through the first bit clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn || (frame_sync_n && fs_d)) k <= 5'h00;
    else if (sclk && !sclk_q && !fs_d && k < 5'h0f) k <= k + 5'h01;
  end
  assign din = tx_word[4'(5'h0f - k)];
  always_ff @(posedge aclk) begin
    rx_done <= frame_sync_n && !fs_q;
    if (!sclk && sclk_q && !frame_sync_n) rx_word <= {rx_word[14:0], dout};
  end
endmodule : host_dsp_model

// [codec_serial_port_test.sv]
`timescale 1ns/1ps
module codec_serial_port_test
  import codec_port_pkg::*;
;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sclk, frame_sync_n, dout, dout_oe, din;
  logic hw_secondary_request, ext_monitor_in, flag_out, rx_done;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata, rnd, cyc;
  logic [15:0] tx_word, rx_word;
  logic [11:0] hi_cnt, gap;
  logic [7:0] c [1:4];
  int n_errors, samples_checked;
  localparam logic [17:0] CORNER [9] = '{18'h10201, 18'h12200, 18'h200ff, 18'h10101,
    18'h10100, 18'h20100, 18'h00000, 18'h105aa, 18'h104ff};
  codec_serial_port codec_serial_port_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sclk(sclk), .frame_sync_n(frame_sync_n),
    .dout(dout), .dout_oe(dout_oe), .din(din), .hw_secondary_request(hw_secondary_request),
    .ext_monitor_in(ext_monitor_in), .flag_out(flag_out));
  host_dsp_model host_dsp_model_i (.aclk(aclk), .aresetn(aresetn), .sclk(sclk),
    .frame_sync_n(frame_sync_n), .dout(dout), .tx_word(tx_word), .din(din),
    .rx_word(rx_word), .rx_done(rx_done));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [15:0] sec_out(input logic [15:0] s, input logic m);
    if (s[13] && s[10:8] >= 3'h1 && s[10:8] <= 3'h4) return {m, 7'h00, c[s[10:8]]};
    return {m, 15'h0000};
  endfunction : sec_out
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  task automatic results;
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic frame;
    do @(posedge aclk); while (rx_done !== 1'b1);
  endtask : frame
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Gap counter is the bench's own view of frame spacing
  always @(posedge aclk) begin
    if (aresetn !== 1'b1) begin
      cyc <= '0;
      hi_cnt <= '0;
      gap <= '0;
    end else begin
      cyc <= cyc + 32'h1;
      if (frame_sync_n === 1'b1) hi_cnt <= hi_cnt + 12'h001;
      else begin
        if (hi_cnt != '0) gap <= hi_cnt;
        hi_cnt <= '0;
      end
    end
    if (cyc == 32'd60000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    logic [1:0] r, kind;
    logic [31:0] v;
    logic [15:0] p, s, a;
    logic [17:0] t;
    logic pend, prev, m;
    aresetn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, hw_secondary_request, ext_monitor_in} = '0;
    {awaddr, araddr, wdata, tx_word} = '0;
    rnd = 32'h00014dfc;
    n_errors = 0;
    samples_checked = 0;
    c = '{8'h00, 8'h00, 8'h00, 8'h00};
    prev = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, v, r);
    check(v, 32'h00000000);
    rd(8'h14, v, r);
    check(v, 32'h00000000);
    check(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_DAC_IN, 32'h0000ffff, r);
    check(32'(r), 32'(RESP_SLVERR));
    frame();
    for (int i = 0; i < 17; i++) begin
      rnd = nxt(rnd);
      t = i < 9 ? CORNER[i] : {rnd[1:0] == 2'h3 ? 2'h0 : rnd[1:0], 2'h0, rnd[2], 2'h0,
        rnd[6:4], rnd[15:8]};
      kind = t[17:16];
      s = t[15:0];
      m = rnd[3];
      p = rnd[31:16];
      p[0] = kind == 2'h1 ? 1'b1 : c[1][0] & p[0];
      rnd = nxt(rnd);
      a = rnd[15:0];
      wr(ADDR_ADC_OUT, {16'h0000, a}, r);
      check(32'(r), 32'(RESP_OKAY));
      rd(ADDR_ADC_OUT, v, r);
      check(v, 32'(a));
      tx_word <= p;
      hw_secondary_request <= kind == 2'h2;
      ext_monitor_in <= m;
      frame();
      hw_secondary_request <= 1'b0;
      check(32'(rx_word), 32'(a));
      check(32'(gap), prev ? 32'd896 : 32'd1920);
      rd(ADDR_DAC_IN, v, r);
      check(v, 32'(p));
      pend = kind == 2'h2 || (kind == 2'h1 && !c[1][0]);
      if (pend) begin
        tx_word <= s;
        p = sec_out(s, m);
        frame();
        check(32'(rx_word), 32'(p));
        check(32'(gap), 32'd896);
        rd(ADDR_SEC_WORD, v, r);
        check(v, 32'(s));
        if (!s[13] && s[10:8] >= 3'h1 && s[10:8] <= 3'h4) c[s[10:8]] = s[7:0];
        rd(ADDR_CTRL, v, r);
        check(v, {c[4], c[3], c[2], c[1]});
        check(32'(flag_out), 32'(c[2][0]));
      end
      prev = pend;
    end
    results();
  end
endmodule : codec_serial_port_test
bind codec_serial_port codec_serial_port_monitor codec_serial_port_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .sclk(sclk), .frame_sync_n(frame_sync_n), .dout_oe(dout_oe));
